// ===== rtl/rsb_pkg.sv
// Purpose: Shared constants for the raw status bank of the output drivers and pins
// Assumes: Word index times four is the Avalon byte address
// Notes: Register data is 16 bits wide, in the low half of the 32-bit bus word
package rsb_pkg;
	localparam int RSB_NWORDS = 5;
	localparam int RSB_WORD_W = 16;
	localparam int RSB_DRV_W = 8;
	localparam int RSB_PIN_W = 32;
	typedef logic [15:0] rsb_idx_t;
	typedef logic [RSB_WORD_W-1:0] rsb_word_t;
	// Word slots: enable done, disable done, thermal, pins 1-16, pins 17-32
	localparam int RSB_W_ENA = 0;
	localparam int RSB_W_DIS = 1;
	localparam int RSB_W_THERM = 2;
	localparam int RSB_W_PLO = 3;
	localparam int RSB_W_PMID = 4;
	localparam rsb_idx_t RSB_RAW_IDX [RSB_NWORDS] = '{16'h188C, 16'h188D, 16'h188E, 16'h1890,
		16'h1891};
	localparam rsb_idx_t RSB_MASK_IDX [RSB_NWORDS] = '{16'h184C, 16'h184D, 16'h184E, 16'h1850,
		16'h1851};
	localparam rsb_idx_t RSB_STICKY_IDX [RSB_NWORDS] = '{16'h180C, 16'h180D, 16'h180E,
		16'h1810, 16'h1811};
	localparam rsb_idx_t RSB_CLR_IDX [RSB_NWORDS] = '{16'h18CC, 16'h18CD, 16'h18CE, 16'h18D0,
		16'h18D1};
	localparam int RSB_SPK_RIGHT_BIT = 7;
	localparam int RSB_SPK_LEFT_BIT = 6;
	localparam int RSB_THERM_WARN_BIT = 2;
	localparam int RSB_THERM_LIMIT_BIT = 1;
	localparam int RSB_SHUTDOWN_BIT = 0;
	localparam rsb_word_t RSB_RAW_RESET = 16'h0000;
	localparam rsb_word_t RSB_MASK_RESET = 16'hFFFF;
	localparam logic [31:0] RSB_RDATA_RESET = 32'h0000_0000;

	function automatic logic [15:0] rsb_byte_addr(input rsb_idx_t idx);
		return {idx[13:0], 2'b00};
	endfunction : rsb_byte_addr
endpackage : rsb_pkg

// ===== rtl/rsb_word_if.sv
// Purpose: Carrier between the bank top and one status word slice
// Assumes: One instance per status word
// Notes: wmask is the byte-enable expanded to bits
`timescale 1ns/10ps
`default_nettype none
interface rsb_word_if;
	logic [15:0] raw_in;
	logic [15:0] raw;
	logic [15:0] sticky;
	logic [15:0] mask;
	logic [15:0] wdata;
	logic [15:0] wmask;
	logic clr_we;
	logic mask_we;
	modport word (input raw_in, wdata, wmask, clr_we, mask_we, output raw, sticky, mask);
	modport ctrl (output raw_in, wdata, wmask, clr_we, mask_we, input raw, sticky, mask);
endinterface : rsb_word_if
`default_nettype wire

// ===== rtl/rsb_irq_word.sv
// Purpose: One raw status word with its sticky event bits and mask
// Assumes: raw_in is already qualified and synchronous to core_clk
// Notes: A rising raw bit sets its sticky bit; set beats a same-cycle clear
`timescale 1ns/10ps
`default_nettype none
module rsb_irq_word (
	input wire logic core_clk,
	input wire logic sys_rst,
	rsb_word_if.word wif
);
	import rsb_pkg::*;
	rsb_word_t raw_ff;
	rsb_word_t sticky_ff;
	rsb_word_t mask_ff;
	rsb_word_t nxt_sticky;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			raw_ff <= RSB_RAW_RESET;
		end else begin
			raw_ff <= wif.raw_in;
		end
	end

	always_comb begin
		nxt_sticky = sticky_ff;
		if (wif.clr_we) begin
			nxt_sticky = nxt_sticky & ~(wif.wdata & wif.wmask);
		end
		nxt_sticky = nxt_sticky | (wif.raw_in & ~raw_ff);
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sticky_ff <= RSB_RAW_RESET;
		end else begin
			sticky_ff <= nxt_sticky;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mask_ff <= RSB_MASK_RESET;
		end else if (wif.mask_we) begin
			mask_ff <= (mask_ff & ~wif.wmask) | (wif.wdata & wif.wmask);
		end
	end

	assign wif.raw = raw_ff;
	assign wif.sticky = sticky_ff;
	assign wif.mask = mask_ff;
endmodule : rsb_irq_word
`default_nettype wire

// ===== rtl/rsb_bus_ack.sv
// Purpose: Avalon-MM waitrequest handshake, one wait cycle per request
// Assumes: Master holds its request until it sees waitrequest low
// Notes: accept marks the single edge at which a transfer completes
`timescale 1ns/10ps
`default_nettype none
module rsb_bus_ack (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic req,
	output logic waitrequest,
	output logic take,
	output logic accept
);
	logic waitrequest_ff;

	// Low for exactly one cycle after a request is seen, so the read mux is registered
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			waitrequest_ff <= 1'b1;
		end else begin
			waitrequest_ff <= !(req && waitrequest_ff);
		end
	end

	assign waitrequest = waitrequest_ff;
	assign take = req && waitrequest_ff;
	assign accept = req && !waitrequest_ff;
endmodule : rsb_bus_ack
`default_nettype wire

// ===== rtl/rsb_raw_status.sv
// Purpose: Raw status bank for driver sequencing, speaker thermal and pin levels
// Assumes: All status inputs are synchronous to core_clk
// Notes: Raw words are read-only; sticky, clear and mask words drive irq
`timescale 1ns/10ps
`default_nettype none
module rsb_raw_status (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [15:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [rsb_pkg::RSB_DRV_W-1:0] enable_done_in,
	input wire logic [rsb_pkg::RSB_DRV_W-1:0] disable_done_in,
	input wire logic spk_thermal_warning,
	input wire logic spk_thermal_limit,
	input wire logic spk_shutdown_complete,
	input wire logic [rsb_pkg::RSB_PIN_W-1:0] pin_level_in,
	input wire logic [rsb_pkg::RSB_PIN_W-1:0] pin_is_gp_input,
	input wire logic [rsb_pkg::RSB_PIN_W-1:0] dsp_owned_pin,
	output logic irq
);
	import rsb_pkg::*;

	logic [RSB_NWORDS-1:0][RSB_WORD_W-1:0] raw_in_arr;
	logic [RSB_NWORDS-1:0][RSB_WORD_W-1:0] w_raw;
	logic [RSB_NWORDS-1:0][RSB_WORD_W-1:0] w_sticky;
	logic [RSB_NWORDS-1:0][RSB_WORD_W-1:0] w_mask;
	logic [RSB_NWORDS-1:0] hit_raw;
	logic [RSB_NWORDS-1:0] hit_mask;
	logic [RSB_NWORDS-1:0] hit_sticky;
	logic [RSB_NWORDS-1:0] hit_clr;
	logic [RSB_PIN_W-1:0] pin_qual;
	rsb_word_t therm_word;
	rsb_word_t wdata16;
	rsb_word_t wmask16;
	rsb_word_t rd_word;
	logic [31:0] readdata_ff;
	logic irq_ff;
	logic req;
	logic take;
	logic accept;
	logic wait_int;
	logic irq_any;

	assign req = avs_read || avs_write;

	rsb_bus_ack u_ack (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.req(req),
		.waitrequest(wait_int),
		.take(take),
		.accept(accept)
	);

	// Pins owned by the DSP or not set as inputs read zero, never a stale level
	assign pin_qual = pin_level_in & pin_is_gp_input & ~dsp_owned_pin;

	always_comb begin
		therm_word = RSB_RAW_RESET;
		therm_word[RSB_THERM_WARN_BIT] = spk_thermal_warning;
		therm_word[RSB_THERM_LIMIT_BIT] = spk_thermal_limit;
		therm_word[RSB_SHUTDOWN_BIT] = spk_shutdown_complete;
	end

	always_comb begin
		raw_in_arr = '0;
		raw_in_arr[RSB_W_ENA][RSB_DRV_W-1:0] = enable_done_in;
		raw_in_arr[RSB_W_DIS][RSB_DRV_W-1:0] = disable_done_in;
		raw_in_arr[RSB_W_THERM] = therm_word;
		raw_in_arr[RSB_W_PLO] = pin_qual[15:0];
		raw_in_arr[RSB_W_PMID] = pin_qual[31:16];
	end

	// Address decode against the byte address of each word
	always_comb begin
		hit_raw = '0;
		hit_mask = '0;
		hit_sticky = '0;
		hit_clr = '0;
		for (int i = 0; i < RSB_NWORDS; i++) begin
			hit_raw[i] = (avs_address == rsb_byte_addr(RSB_RAW_IDX[i]));
			hit_mask[i] = (avs_address == rsb_byte_addr(RSB_MASK_IDX[i]));
			hit_sticky[i] = (avs_address == rsb_byte_addr(RSB_STICKY_IDX[i]));
			hit_clr[i] = (avs_address == rsb_byte_addr(RSB_CLR_IDX[i]));
		end
	end

	assign wdata16 = avs_writedata[15:0];
	assign wmask16 = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	rsb_word_if w_if [RSB_NWORDS] ();

	for (genvar gi = 0; gi < RSB_NWORDS; gi++) begin : g_word
		// Raw words have no write strobe at all, so writes there fall away
		assign w_if[gi].raw_in = raw_in_arr[gi];
		assign w_if[gi].wdata = wdata16;
		assign w_if[gi].wmask = wmask16;
		assign w_if[gi].clr_we = accept && avs_write && hit_clr[gi];
		assign w_if[gi].mask_we = accept && avs_write && hit_mask[gi];
		assign w_raw[gi] = w_if[gi].raw;
		assign w_sticky[gi] = w_if[gi].sticky;
		assign w_mask[gi] = w_if[gi].mask;
		rsb_irq_word u_word (
			.core_clk(core_clk),
			.sys_rst(sys_rst),
			.wif(w_if[gi])
		);
	end

	// Clear words are write-only and read zero; unmapped reads zero too
	always_comb begin
		rd_word = RSB_RAW_RESET;
		for (int i = 0; i < RSB_NWORDS; i++) begin
			if (hit_raw[i]) begin
				rd_word = w_raw[i];
			end
			if (hit_mask[i]) begin
				rd_word = w_mask[i];
			end
			if (hit_sticky[i]) begin
				rd_word = w_sticky[i];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			readdata_ff <= RSB_RDATA_RESET;
		end else if (take && avs_read) begin
			readdata_ff <= {16'h0000, rd_word};
		end
	end

	always_comb begin
		irq_any = 1'b0;
		for (int i = 0; i < RSB_NWORDS; i++) begin
			irq_any = irq_any | (|(w_sticky[i] & ~w_mask[i]));
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= irq_any;
		end
	end

	assign avs_readdata = readdata_ff;
	assign avs_waitrequest = wait_int;
	assign irq = irq_ff;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	logic past_valid_ff;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			past_valid_ff <= 1'b0;
		end else begin
			past_valid_ff <= 1'b1;
		end
	end

	// Raw words lag their inputs by one edge; nothing else may feed them
	a_ena_done_track: assert property (past_valid_ff |->
		w_raw[RSB_W_ENA] == {8'h00, $past(enable_done_in)})
		else $error("enable-done word does not follow the driver inputs");

	sequence s_left_up;
		$rose(enable_done_in[RSB_SPK_LEFT_BIT]);
	endsequence

	sequence s_left_up_seen;
		w_raw[RSB_W_ENA][RSB_SPK_LEFT_BIT] && w_sticky[RSB_W_ENA][RSB_SPK_LEFT_BIT];
	endsequence

	// The sticky copy rises on the same edge as the raw bit, not one later
	a_spk_left_up: assert property (s_left_up |=> s_left_up_seen)
		else $error("speaker left power-up done not reported");

	// Reads are answered from a register loaded at the take edge
	sequence s_read_taken;
		take && avs_read;
	endsequence

	sequence s_read_done;
		!avs_waitrequest;
	endsequence

	a_ena_readback: assert property (s_read_taken ##0 hit_raw[RSB_W_ENA] |=>
		avs_readdata == {16'h0000, $past(w_raw[RSB_W_ENA])})
		else $error("enable-done word read back wrong");

	a_dis_done_track: assert property (past_valid_ff |->
		w_raw[RSB_W_DIS] == {8'h00, $past(disable_done_in)})
		else $error("disable-done word does not follow the driver inputs");

	a_dis_readback: assert property (s_read_taken ##0 hit_raw[RSB_W_DIS] |=>
		avs_readdata == {16'h0000, $past(w_raw[RSB_W_DIS])})
		else $error("disable-done word read back wrong");

	a_therm_warn: assert property (past_valid_ff |->
		w_raw[RSB_W_THERM][RSB_THERM_WARN_BIT] == $past(spk_thermal_warning))
		else $error("thermal warning bit wrong");

	a_therm_limit: assert property (past_valid_ff |->
		w_raw[RSB_W_THERM][RSB_THERM_LIMIT_BIT] == $past(spk_thermal_limit))
		else $error("thermal limit bit wrong");

	a_shut_done: assert property (past_valid_ff |->
		w_raw[RSB_W_THERM][RSB_SHUTDOWN_BIT] == $past(spk_shutdown_complete)
		&& w_raw[RSB_W_THERM][15:3] == 13'h0000)
		else $error("shutdown-complete bit wrong");

	a_pin_level: assert property (past_valid_ff |->
		{w_raw[RSB_W_PMID], w_raw[RSB_W_PLO]} == $past(pin_qual))
		else $error("pin level words wrong");

	a_pin_readback: assert property (s_read_taken ##0 hit_raw[RSB_W_PMID] |=>
		avs_readdata == {16'h0000, $past(w_raw[RSB_W_PMID])})
		else $error("upper pin level word read back wrong");

	a_dsp_pin_hidden: assert property (past_valid_ff |->
		({w_raw[RSB_W_PMID], w_raw[RSB_W_PLO]} & $past(dsp_owned_pin | ~pin_is_gp_input))
		== 32'h0000_0000)
		else $error("pin not configured as input reports a level");

	// A refused pin may keep an old sticky bit but must never raise a new one
	a_pin_no_sticky: assert property (past_valid_ff |->
		({w_sticky[RSB_W_PMID], w_sticky[RSB_W_PLO]}
		& ~$past({w_sticky[RSB_W_PMID], w_sticky[RSB_W_PLO]})
		& $past(dsp_owned_pin | ~pin_is_gp_input)) == 32'h0000_0000)
		else $error("refused pin raised its sticky bit");

	a_mask_gates_irq: assert property (past_valid_ff |-> irq == $past(irq_any))
		else $error("interrupt output does not follow unmasked sticky bits");

	a_mask_blocks: assert property ((w_sticky & ~w_mask) == '0 ##1
		(w_sticky & ~w_mask) == '0 |-> !irq)
		else $error("masked event raised the interrupt");

	// Set beats a same-cycle clear, so every new raw bit shows up as sticky
	a_sticky_sets: assert property (past_valid_ff |->
		(w_raw & ~$past(w_raw) & ~w_sticky) == '0)
		else $error("rising raw bit did not set its sticky bit");

	sequence s_clr_write;
		accept && avs_write && hit_clr[RSB_W_THERM];
	endsequence

	a_clear_sticky: assert property (s_clr_write |=> (w_sticky[RSB_W_THERM]
		& $past(wdata16 & wmask16)
		& ~(w_raw[RSB_W_THERM] & ~$past(w_raw[RSB_W_THERM]))) == 16'h0000)
		else $error("clear write left a sticky bit set");

	a_sticky_readback: assert property (s_read_taken ##0 hit_sticky[RSB_W_THERM] |=>
		avs_readdata == {16'h0000, $past(w_sticky[RSB_W_THERM])})
		else $error("sticky word read back wrong");

	sequence s_mask_write;
		accept && avs_write && hit_mask[RSB_W_THERM];
	endsequence

	// Only the enabled byte lanes of a mask write may change
	a_mask_write: assert property (s_mask_write |=> w_mask[RSB_W_THERM] ==
		(($past(w_mask[RSB_W_THERM]) & ~$past(wmask16)) | $past(wdata16 & wmask16)))
		else $error("mask write did not honour the byte lanes");

	a_mask_hold: assert property (!(accept && avs_write && (|hit_mask)) |=>
		$stable(w_mask))
		else $error("mask changed without a mask write");

	a_mask_readback: assert property (s_read_taken ##0 hit_mask[RSB_W_THERM] |=>
		avs_readdata == {16'h0000, $past(w_mask[RSB_W_THERM])})
		else $error("mask word read back wrong");

	sequence s_raw_write;
		accept && avs_write && (|hit_raw);
	endsequence

	// A raw word has no write strobe, so a write there leaves all state alone
	a_raw_write_ignored: assert property (s_raw_write |=> $stable(w_mask)
		&& w_raw == $past(raw_in_arr) && ($past(w_sticky) & ~w_sticky) == '0)
		else $error("write to a raw word changed stored state");

	// Checked at the first edge with reset low, where disable iff lets go
	sequence s_reset_gone;
		$fell(sys_rst);
	endsequence

	a_reset_outputs: assert property (s_reset_gone |-> !irq && avs_waitrequest
		&& avs_readdata == RSB_RDATA_RESET)
		else $error("outputs not at their reset values after reset");

	a_reset_words: assert property (s_reset_gone |-> w_raw == '0
		&& w_sticky == '0 && w_mask == '1)
		else $error("status words not at their reset values after reset");

	a_read_latency: assert property (s_read_taken |=> s_read_done)
		else $error("read not answered one cycle after it was taken");

	a_write_latency: assert property (take && avs_write |=> !avs_waitrequest)
		else $error("write not answered one cycle after it was taken");

	a_raw_readback: assert property (s_read_taken ##0 hit_raw[RSB_W_THERM] |=>
		avs_readdata == {16'h0000, $past(w_raw[RSB_W_THERM])})
		else $error("raw word read back wrong");

	a_clr_reads_zero: assert property (s_read_taken ##0 (|hit_clr) |=>
		avs_readdata == RSB_RDATA_RESET)
		else $error("write-only clear word did not read zero");

	sequence s_no_hit;
		!(|{hit_raw, hit_mask, hit_sticky, hit_clr});
	endsequence

	a_unmapped_zero: assert property (s_read_taken ##0 s_no_hit |=>
		avs_readdata == RSB_RDATA_RESET)
		else $error("unmapped read did not return zero");

	a_readdata_upper: assert property (avs_readdata[31:16] == 16'h0000)
		else $error("upper half of read data not zero");

	a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
endmodule : rsb_raw_status
`default_nettype wire

// ===== dv/test_rsb_raw_status.sv
// Purpose: Self-checking bench for the raw status bank
// Assumes: Slave answers a request one cycle after taking it
// Notes: Reads queue their expected word; a monitor checks it at the answer edge
`timescale 1ns/10ps
`default_nettype none
module test_rsb_raw_status;
	import rsb_pkg::*;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [15:0] avs_address = 16'h0000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'h3;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [RSB_DRV_W-1:0] enable_done_in = 8'h00;
	logic [RSB_DRV_W-1:0] disable_done_in = 8'h00;
	logic spk_thermal_warning = 1'b0;
	logic spk_thermal_limit = 1'b0;
	logic spk_shutdown_complete = 1'b0;
	logic [RSB_PIN_W-1:0] pin_level_in = 32'h0000_0000;
	logic [RSB_PIN_W-1:0] pin_is_gp_input = 32'hFFFF_FFFF;
	logic [RSB_PIN_W-1:0] dsp_owned_pin = 32'h0000_0000;
	logic irq;
	logic [15:0] lfsr_ff = 16'hEE00;
	logic [31:0] exp_q [$];
	int failures = 0;
	int n_tests = 0;

	always #25 core_clk = ~core_clk;

	rsb_raw_status i_rsb_raw_status (.core_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .enable_done_in,
		.disable_done_in, .spk_thermal_warning, .spk_thermal_limit, .spk_shutdown_complete,
		.pin_level_in, .pin_is_gp_input, .dsp_owned_pin, .irq);

	function automatic logic [15:0] rnd();
		lfsr_ff = {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
		return lfsr_ff;
	endfunction : rnd

	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	task automatic bus(input logic wr, input rsb_idx_t idx, input logic [15:0] wd);
		@(posedge core_clk);
		avs_address <= 16'(idx * 4);
		avs_read <= ~wr;
		avs_write <= wr;
		avs_writedata <= {16'h0000, wd};
		// Only the watchdog ends a hang
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic rd(input rsb_idx_t idx, input logic [15:0] exp);
		exp_q.push_back({16'h0000, exp});
		bus(1'b0, idx, 16'h0000);
	endtask : rd

	task automatic check_word(input logic [31:0] exp);
		n_tests++;
		if (avs_readdata !== exp) begin
			failures++;
			$display("wrong value at %0t: read %h expected %h", $time, avs_readdata, exp);
		end
	endtask : check_word

	task automatic check_irq(input logic exp);
		n_tests++;
		if (irq !== exp) begin
			failures++;
			$display("wrong value at %0t: irq %b expected %b", $time, irq, exp);
		end
	endtask : check_irq

	always @(posedge core_clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
			check_word(exp_q.pop_front());
	end

	initial begin
		repeat (5000) @(posedge core_clk);
		failures++;
		$display("wrong value at %0t: run timed out", $time);
		print_verdict();
	end

	initial begin
		logic [15:0] e;
		logic [15:0] d;
		logic [31:0] m;
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		for (int i = 0; i < RSB_NWORDS; i++)
			rd(RSB_RAW_IDX[i], RSB_RAW_RESET);
		rd(RSB_MASK_IDX[RSB_W_THERM], RSB_MASK_RESET);
		$display("test reset values done");
		for (int k = 0; k < 4; k++) begin
			e = rnd();
			d = rnd();
			enable_done_in <= e[7:0];
			disable_done_in <= d[7:0];
			repeat (2) @(posedge core_clk);
			rd(RSB_RAW_IDX[RSB_W_ENA], {8'h00, e[7:0]});
			rd(RSB_RAW_IDX[RSB_W_DIS], {8'h00, d[7:0]});
			bus(1'b1, RSB_RAW_IDX[RSB_W_DIS], ~d);
			rd(RSB_RAW_IDX[RSB_W_DIS], {8'h00, d[7:0]});
		end
		$display("test driver sequencing done");
		for (int k = 0; k < 8; k++) begin
			{spk_thermal_warning, spk_thermal_limit, spk_shutdown_complete} <= k[2:0];
			repeat (2) @(posedge core_clk);
			rd(RSB_RAW_IDX[RSB_W_THERM], 16'(k));
		end
		$display("test speaker thermal done");
		for (int k = 0; k < 4; k++) begin
			m = {rnd(), rnd()};
			e = rnd();
			d = rnd();
			pin_level_in <= m;
			pin_is_gp_input <= (k == 0) ? 32'hFFFF_FFFF : {e, d};
			dsp_owned_pin <= (k == 0) ? 32'h0000_0000 : {d, e};
			if (k != 0)
				m = m & {e, d} & ~{d, e};
			repeat (2) @(posedge core_clk);
			rd(RSB_RAW_IDX[RSB_W_PLO], m[15:0]);
			rd(RSB_RAW_IDX[RSB_W_PMID], m[31:16]);
		end
		check_irq(1'b0);
		$display("test pin levels done");
		// Drop the warning before clearing, so raising it again later is a new rising edge that sets sticky
		{spk_thermal_warning, spk_thermal_limit, spk_shutdown_complete} <= 3'h0;
		repeat (3) @(posedge core_clk);
		bus(1'b1, RSB_CLR_IDX[RSB_W_THERM], 16'hFFFF);
		rd(RSB_STICKY_IDX[RSB_W_THERM], 16'h0000);
		bus(1'b1, RSB_MASK_IDX[RSB_W_THERM], 16'hFFFB);
		repeat (3) @(posedge core_clk);
		check_irq(1'b0);
		spk_thermal_warning <= 1'b1;
		repeat (4) @(posedge core_clk);
		check_irq(1'b1);
		rd(RSB_STICKY_IDX[RSB_W_THERM], 16'h0004);
		bus(1'b1, RSB_MASK_IDX[RSB_W_THERM], 16'hFFFF);
		repeat (3) @(posedge core_clk);
		check_irq(1'b0);
		spk_thermal_warning <= 1'b0;
		bus(1'b1, RSB_MASK_IDX[RSB_W_THERM], 16'hFFFB);
		repeat (3) @(posedge core_clk);
		check_irq(1'b1);
		bus(1'b1, RSB_CLR_IDX[RSB_W_THERM], 16'h0004);
		repeat (3) @(posedge core_clk);
		check_irq(1'b0);
		rd(RSB_CLR_IDX[RSB_W_THERM], 16'h0000);
		rd(16'h1700, 16'h0000);
		avs_byteenable <= 4'h1;
		bus(1'b1, RSB_MASK_IDX[RSB_W_THERM], 16'h0000);
		avs_byteenable <= 4'h3;
		rd(RSB_MASK_IDX[RSB_W_THERM], 16'hFF00);
		$display("test interrupt path done");
		@(posedge core_clk);
		if (exp_q.size() != 0) begin
			failures++;
			$display("wrong value at %0t: reads left unanswered", $time);
		end
		print_verdict();
	end
endmodule : test_rsb_raw_status
`default_nettype wire
